// ==== verilog/tcr_top.sv ====
`timescale 1ns/1ns
`include "tcr_cfg.svh"
// Function
// - counter readable and writable through high and low byte locations.
// - counter reads and writes move both bytes together via latch.
// - one shared high-byte latch serves counter and compare writes and counter and capture reads.
// - counter write suppresses next-tick compare match on all channels.
// - compare values held sixteen bits, compared on every timer tick.
// - three independent compare channels A, B, C with high/low bytes.
// - counter equal to compare signals match, usable for interrupt.
// - match flag sets in tick after the equality tick.
// - compare register bytes commit together on low byte write.
// - capture register read-only and never loaded.
// - capture bytes returned together via shared latch.
// - compare and capture bytes reset to zero.
module tcr_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire tcr_pkg::tcr_addr_t reg_addr,
  input wire tcr_pkg::tcr_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output tcr_pkg::tcr_byte_t reg_rdata,
  output logic irq
);
  import tcr_pkg::*;
  // ==================================================
  // reset synchroniser
  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end
  // ==================================================
  // state
  tcr_byte_t hold_high;
  tcr_word_t timer_count;
  tcr_word_t compare_values [`TCR_NCH];
  tcr_word_t capture_value;
  logic [2:0] clk_sel;
  logic [2:0] flags;
  logic [2:0] mask;
  logic cnt_written;
  tcr_byte_t next_hold_high;
  tcr_word_t next_timer_count;
  tcr_word_t next_compare_values [`TCR_NCH];
  logic [2:0] next_clk_sel;
  logic [2:0] next_flags;
  logic [2:0] next_mask;
  logic next_cnt_written;
  tcr_byte_t next_rdata;
  logic next_irq;
  logic tick;
  logic [2:0] pend;
  logic [2:0] mset;
  // capture stays at reset value, nothing loads it
  assign capture_value = `TCR_RST_WORD;
  // ==================================================
  // timer tick and compare channels
  tcr_tick_gen u_tick (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .clk_sel(clk_sel),
    .tick(tick)
  );
  genvar gi;
  generate
    for (gi = 0; gi < `TCR_NCH; gi++) begin : g_ch
      tcr_cmp_chan u_ch (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .tick(tick),
        .block(cnt_written),
        .count(timer_count),
        .compare(compare_values[gi]),
        .match_pend(pend[gi]),
        .match_set(mset[gi])
      );
    end
  endgenerate
  // ==================================================
  // register writes, counter and flags
  always_comb begin
    next_hold_high = hold_high;
    next_timer_count = timer_count;
    for (int i = 0; i < `TCR_NCH; i++) begin
      next_compare_values[i] = compare_values[i];
    end
    next_clk_sel = clk_sel;
    next_mask = mask;
    next_flags = flags;
    next_cnt_written = cnt_written;
    // written flag covers the next tick only
    if (tick) begin
      next_cnt_written = 1'b0;
      next_timer_count = timer_count + `TCR_CNT_ONE;
    end
    if (reg_wr) begin
      case (reg_addr)
        // high byte writes park in the latch
        `TCR_OFS_CNT_HIGH, `TCR_OFS_CMPA_HIGH, `TCR_OFS_CMPB_HIGH,
        `TCR_OFS_CMPC_HIGH: next_hold_high = reg_wdata;
        // low write commits the whole count, blocks match
        `TCR_OFS_CNT_LOW: begin
          next_timer_count = {hold_high, reg_wdata};
          next_cnt_written = 1'b1;
        end
        // compare commits both bytes from shared latch
        `TCR_OFS_CMPA_LOW: next_compare_values[0] = {hold_high, reg_wdata};
        `TCR_OFS_CMPB_LOW: next_compare_values[1] = {hold_high, reg_wdata};
        `TCR_OFS_CMPC_LOW: next_compare_values[2] = {hold_high, reg_wdata};
        `TCR_OFS_CTRL: next_clk_sel = reg_wdata[2:0];
        `TCR_OFS_MASK: next_mask = reg_wdata[2:0];
        `TCR_OFS_STATUS: next_flags = flags & ~reg_wdata[2:0];
        default: next_hold_high = hold_high;
      endcase
    end
    // hardware set wins over a clear
    next_flags = next_flags | mset;
    // a counter or capture low read snaps the high byte into the latch
    next_rdata = `TCR_RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        `TCR_OFS_CNT_LOW: begin
          next_rdata = timer_count[7:0];
          next_hold_high = timer_count[15:8];
        end
        // capture read through the same latch
        `TCR_OFS_CAP_LOW: begin
          next_rdata = capture_value[7:0];
          next_hold_high = capture_value[15:8];
        end
        `TCR_OFS_CMPA_LOW: next_rdata = compare_values[0][7:0];
        `TCR_OFS_CMPB_LOW: next_rdata = compare_values[1][7:0];
        `TCR_OFS_CMPC_LOW: next_rdata = compare_values[2][7:0];
        `TCR_OFS_CMPA_HIGH: next_rdata = compare_values[0][15:8];
        `TCR_OFS_CMPB_HIGH: next_rdata = compare_values[1][15:8];
        `TCR_OFS_CMPC_HIGH: next_rdata = compare_values[2][15:8];
        // counter and capture high locations read the shared latch
        `TCR_OFS_CNT_HIGH, `TCR_OFS_CAP_HIGH: next_rdata = hold_high;
        `TCR_OFS_CTRL: next_rdata = {5'h00, clk_sel};
        `TCR_OFS_STATUS: next_rdata = {5'h00, flags};
        `TCR_OFS_MASK: next_rdata = {5'h00, mask};
        default: next_rdata = `TCR_RST_BYTE;
      endcase
    end
    next_irq = |(next_flags & next_mask);
  end
  // registers
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hold_high <= `TCR_RST_BYTE;
      timer_count <= `TCR_RST_WORD;
      for (int i = 0; i < `TCR_NCH; i++) begin
        compare_values[i] <= `TCR_RST_WORD;
      end
      clk_sel <= `TCR_RST_PRESC;
      mask <= `TCR_RST_FLAGS;
      flags <= `TCR_RST_FLAGS;
      cnt_written <= 1'b0;
      reg_rdata <= `TCR_RST_BYTE;
      irq <= 1'b0;
    end else begin
      hold_high <= next_hold_high;
      timer_count <= next_timer_count;
      for (int i = 0; i < `TCR_NCH; i++) begin
        compare_values[i] <= next_compare_values[i];
      end
      clk_sel <= next_clk_sel;
      mask <= next_mask;
      flags <= next_flags;
      cnt_written <= next_cnt_written;
      reg_rdata <= next_rdata;
      irq <= next_irq;
    end
  end
  // ==================================================
  // checks
  // a counter write blocks a match at the next tick
  chk_write_blocks: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (tick && cnt_written) |=> (mset == 3'h0))
    else $error("counter write did not block match");
  chk_block_flag: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (reg_wr && reg_addr == `TCR_OFS_CNT_LOW) |=> cnt_written)
    else $error("counter write not remembered");
  chk_pend_clear: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (tick && cnt_written) |=> (pend == 3'h0))
    else $error("match not suppressed after counter write");
  // equality at a tick gives a pending match
  chk_eq_pend: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (tick && !cnt_written && timer_count == compare_values[0]) |=> pend[0])
    else $error("equality not recorded for channel a");
  chk_flag_set: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    mset[1] |=> flags[1])
    else $error("match flag b not set");
  // compare commits both bytes from the latch
  chk_cmp_commit: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (reg_wr && reg_addr == `TCR_OFS_CMPC_LOW) |=>
    (compare_values[2] == {$past(hold_high), $past(reg_wdata)}))
    else $error("compare c not committed whole");
  chk_low_latch: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (reg_rd && reg_addr == `TCR_OFS_CNT_LOW) |=>
    (hold_high == $past(timer_count[15:8]) && reg_rdata == $past(timer_count[7:0])))
    else $error("count low read did not latch high");
  chk_cap_zero: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (reg_rd && reg_addr == `TCR_OFS_CAP_LOW) |=> (reg_rdata == 8'h00))
    else $error("capture register not zero");
  // irq follows flags and mask
  chk_irq_level: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    irq == |(flags & mask))
    else $error("irq mismatch");
  cov_cnt_write: cover property (@(posedge mclk) reg_wr && reg_addr == `TCR_OFS_CNT_LOW);
  cov_match_a: cover property (@(posedge mclk) mset[0]);
  cov_irq: cover property (@(posedge mclk) irq);
  cov_cap_read: cover property (@(posedge mclk) reg_rd && reg_addr == `TCR_OFS_CAP_LOW);
endmodule : tcr_top

// ==== verilog/tcr_cfg.svh ====
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH
// register byte offsets
`define TCR_OFS_CNT_LOW 9'h124
`define TCR_OFS_CNT_HIGH 9'h125
`define TCR_OFS_CAP_LOW 9'h126
`define TCR_OFS_CAP_HIGH 9'h127
`define TCR_OFS_CMPA_LOW 9'h128
`define TCR_OFS_CMPA_HIGH 9'h129
`define TCR_OFS_CMPB_LOW 9'h12a
`define TCR_OFS_CMPB_HIGH 9'h12b
`define TCR_OFS_CMPC_LOW 9'h12c
`define TCR_OFS_CMPC_HIGH 9'h12d
`define TCR_OFS_CTRL 9'h130
`define TCR_OFS_STATUS 9'h131
`define TCR_OFS_MASK 9'h132
// reset values
`define TCR_RST_BYTE 8'h00
`define TCR_RST_WORD 16'h0000
`define TCR_RST_FLAGS 3'h0
`define TCR_RST_PRESC 3'h0
// prescaler selection codes and divisor terminal counts
`define TCR_CS_STOP 3'h0
`define TCR_CS_DIV1 3'h1
`define TCR_CS_DIV8 3'h2
`define TCR_CS_DIV64 3'h3
`define TCR_CS_DIV256 3'h4
`define TCR_CS_DIV1024 3'h5
`define TCR_TC_DIV8 10'h007
`define TCR_TC_DIV64 10'h03f
`define TCR_TC_DIV256 10'h0ff
`define TCR_TC_DIV1024 10'h3ff
`define TCR_PRE_ONE 10'h001
`define TCR_CNT_ONE 16'h0001
`define TCR_NCH 3
`endif

// ==== verilog/tcr_pkg.sv ====
package tcr_pkg;
  typedef logic [7:0] tcr_byte_t;
  typedef logic [15:0] tcr_word_t;
  typedef logic [8:0] tcr_addr_t;
endpackage : tcr_pkg

// ==== verilog/tcr_tick_gen.sv ====
`timescale 1ns/1ns
`include "tcr_cfg.svh"
// free running prescaler making one-cycle timer tick enables
module tcr_tick_gen (
  input wire logic mclk,
  input wire logic rst_sync_n,
  input wire logic [2:0] clk_sel,
  output logic tick
);
  import tcr_pkg::*;
  logic [9:0] pre;
  logic [9:0] next_pre;
  logic [9:0] tc;
  // next prescaler value and tick decode
  always_comb begin
    next_pre = pre + `TCR_PRE_ONE;
    case (clk_sel)
      `TCR_CS_DIV8: tc = `TCR_TC_DIV8;
      `TCR_CS_DIV64: tc = `TCR_TC_DIV64;
      `TCR_CS_DIV256: tc = `TCR_TC_DIV256;
      default: tc = `TCR_TC_DIV1024;
    endcase
    case (clk_sel)
      `TCR_CS_STOP: tick = 1'b0;
      `TCR_CS_DIV1: tick = 1'b1;
      `TCR_CS_DIV8, `TCR_CS_DIV64, `TCR_CS_DIV256, `TCR_CS_DIV1024: tick = ((pre & tc) == tc);
      default: tick = 1'b0;
    endcase
  end
  // prescaler register
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pre <= 10'h000;
    end else begin
      pre <= next_pre;
    end
  end
endmodule : tcr_tick_gen

// ==== verilog/tcr_cmp_chan.sv ====
`timescale 1ns/1ns
`include "tcr_cfg.svh"
// one compare channel: equality seen at a tick, flagged at the next tick
module tcr_cmp_chan (
  input wire logic mclk,
  input wire logic rst_sync_n,
  input wire logic tick,
  input wire logic block,
  input wire tcr_pkg::tcr_word_t count,
  input wire tcr_pkg::tcr_word_t compare,
  output logic match_pend,
  output logic match_set
);
  import tcr_pkg::*;
  logic next_pend;
  // set one tick after counter equals compare, unless blocked
  always_comb begin
    next_pend = match_pend;
    match_set = tick && match_pend;
    if (tick) begin
      next_pend = (count == compare) && !block;
    end
  end
  // pending match register
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      match_pend <= 1'b0;
    end else begin
      match_pend <= next_pend;
    end
  end
endmodule : tcr_cmp_chan

// ==== testbench/tcr_cpu_model.sv ====
`timescale 1ns/1ns
// ==========================================
// processor side of the byte-wide register port
module tcr_cpu_model (
  input wire logic mclk,
  output tcr_pkg::tcr_addr_t reg_addr,
  output tcr_pkg::tcr_byte_t reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire tcr_pkg::tcr_byte_t reg_rdata
);
  import tcr_pkg::*;
  // idle bus at time zero
  initial begin
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write cycle; released lines show the inverse so stale values never match
  task automatic wr8(input tcr_addr_t a, input tcr_byte_t d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr8
  // one read cycle; data taken in the cycle after the strobe
  task automatic rd8(input tcr_addr_t a, output tcr_byte_t d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd8
  task automatic wr16(input tcr_addr_t a, input tcr_word_t d);
    wr8(a + 9'h001, d[15:8]);
    wr8(a, d[7:0]);
  endtask : wr16
  task automatic rd16(input tcr_addr_t a, output tcr_word_t d);
    tcr_byte_t lo;
    tcr_byte_t hi;
    rd8(a, lo);
    rd8(a + 9'h001, hi);
    d = {hi, lo};
  endtask : rd16
endmodule : tcr_cpu_model

// ==== testbench/test_timer_compare_capture_regs_16bit.sv ====
`timescale 1ns/1ns
`include "tcr_cfg.svh"
// ==========================================
// register access and compare match bench
module test_timer_compare_capture_regs_16bit;
  import tcr_pkg::*;
  logic mclk;
  logic rst_n;
  tcr_addr_t reg_addr;
  tcr_byte_t reg_wdata;
  logic reg_wr;
  logic reg_rd;
  tcr_byte_t reg_rdata;
  logic irq;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  tcr_word_t w;
  tcr_byte_t b;
  tcr_word_t cw [3] = '{16'h1234, 16'h80ff, 16'hfe01};
  logic [2:0] sel [4] = '{`TCR_CS_DIV8, `TCR_CS_DIV64, `TCR_CS_DIV256, `TCR_CS_DIV1024};
  int div [4] = '{8, 64, 256, 1024};
  tcr_top DUT (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  tcr_cpu_model cpu (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // compare seen against expected
  task automatic check(input string name, input tcr_word_t seen, input tcr_word_t exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // reset values of counter, capture and compare words
    for (int i = 0; i < 5; i++) begin
      cpu.rd16(`TCR_OFS_CNT_LOW + 9'(2 * i), w);
      check("reset word", w, `TCR_RST_WORD);
    end
    for (int i = 0; i < 3; i++) cpu.wr16(`TCR_OFS_CMPA_LOW + 9'(2 * i), cw[i]);
    for (int i = 0; i < 3; i++) begin
      cpu.rd16(`TCR_OFS_CMPA_LOW + 9'(2 * i), w);
      check("compare word", w, cw[i]);
    end
    // last high byte parked wins, whichever register it was aimed at
    cpu.wr8(`TCR_OFS_CMPA_HIGH, 8'h5a);
    cpu.wr8(`TCR_OFS_CMPB_HIGH, 8'ha5);
    cpu.wr8(`TCR_OFS_CMPA_LOW, 8'h3c);
    cpu.rd16(`TCR_OFS_CMPA_LOW, w);
    check("shared latch write", w, 16'ha53c);
    cpu.rd16(`TCR_OFS_CMPB_LOW, w);
    check("compare b kept", w, cw[1]);
    cpu.wr16(`TCR_OFS_CAP_LOW, 16'h7777);
    cpu.rd16(`TCR_OFS_CAP_LOW, w);
    check("capture word", w, `TCR_RST_WORD);
    cpu.wr16(`TCR_OFS_CNT_LOW, 16'hbeef);
    cpu.rd16(`TCR_OFS_CNT_LOW, w);
    check("count word", w, 16'hbeef);
    cpu.rd8(`TCR_OFS_CNT_LOW, b);
    cpu.rd8(`TCR_OFS_CAP_HIGH, b);
    check("shared latch read", {8'h00, b}, 16'h00be);
    // unmapped address
    cpu.wr8(9'h1ff, 8'h77);
    cpu.rd8(9'h1ff, b);
    check("unmapped", {8'h00, b}, 16'h0000);
    // counter write while running blocks the next-tick match on a
    cpu.wr16(`TCR_OFS_CMPA_LOW, 16'h0100);
    cpu.wr16(`TCR_OFS_CMPB_LOW, 16'h0103);
    cpu.wr16(`TCR_OFS_CMPC_LOW, 16'h8000);
    cpu.wr8(`TCR_OFS_STATUS, 8'h07);
    cpu.wr8(`TCR_OFS_MASK, 8'h07);
    cpu.rd8(`TCR_OFS_STATUS, b);
    check("status clear", {8'h00, b}, 16'h0000);
    check("irq idle", {15'h0000, irq}, 16'h0000);
    cpu.wr8(`TCR_OFS_CTRL, {5'h00, `TCR_CS_DIV1});
    cpu.wr16(`TCR_OFS_CNT_LOW, 16'h0100);
    repeat (12) @(posedge mclk);
    cpu.wr8(`TCR_OFS_CTRL, {5'h00, `TCR_CS_STOP});
    cpu.rd8(`TCR_OFS_STATUS, b);
    check("match flags", {8'h00, b}, 16'h0002);
    check("irq raised", {15'h0000, irq}, 16'h0001);
    // interrupt masked then flag cleared
    cpu.wr8(`TCR_OFS_MASK, 8'h05);
    repeat (2) @(posedge mclk);
    check("irq masked", {15'h0000, irq}, 16'h0000);
    cpu.wr8(`TCR_OFS_MASK, 8'h07);
    repeat (2) @(posedge mclk);
    check("irq unmasked", {15'h0000, irq}, 16'h0001);
    cpu.wr8(`TCR_OFS_STATUS, 8'h02);
    cpu.rd8(`TCR_OFS_STATUS, b);
    check("flag cleared", {8'h00, b}, 16'h0000);
    check("irq cleared", {15'h0000, irq}, 16'h0000);
    // each tap gives four ticks in 4N cycles; a flagged, b never, c blocked
    cpu.wr16(`TCR_OFS_CMPA_LOW, 16'h0002);
    cpu.wr16(`TCR_OFS_CMPB_LOW, 16'h00ff);
    cpu.wr16(`TCR_OFS_CMPC_LOW, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      cpu.wr16(`TCR_OFS_CNT_LOW, 16'h0000);
      cpu.wr8(`TCR_OFS_STATUS, 8'h07);
      cpu.wr8(`TCR_OFS_CTRL, {5'h00, sel[i]});
      repeat (4 * div[i] - 2) @(posedge mclk);
      cpu.wr8(`TCR_OFS_CTRL, {5'h00, `TCR_CS_STOP});
      cpu.rd16(`TCR_OFS_CNT_LOW, w);
      check("prescaled count", w, 16'h0004);
      cpu.rd8(`TCR_OFS_STATUS, b);
      check("prescaled flags", {8'h00, b}, 16'h0001);
    end
    // mid-run reset returns written compare word a to zero
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    check("irq in reset", {15'h0000, irq}, 16'h0000);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    cpu.rd16(`TCR_OFS_CMPA_LOW, w);
    check("compare after reset", w, `TCR_RST_WORD);
    conclude();
  end
endmodule : test_timer_compare_capture_regs_16bit
